// ---- pkg/urm_pkg.sv ----
package urm_pkg;
    localparam logic [2:0] OFF_0 = 3'h0;
    localparam logic [2:0] OFF_1 = 3'h1;
    localparam logic [2:0] OFF_2 = 3'h2;
    localparam logic [2:0] OFF_3 = 3'h3;
    localparam logic [2:0] OFF_4 = 3'h4;
    localparam logic [2:0] OFF_5 = 3'h5;
    localparam logic [2:0] OFF_6 = 3'h6;
    localparam logic [2:0] OFF_7 = 3'h7;
    localparam logic [7:0] LINE_CTRL_ENH_KEY = 8'hbf;
    localparam int LINE_CTRL_DIV_BIT = 7;
    localparam int ENH_UNLOCK_BIT = 4;
    localparam int FEATURE_MAP_BIT = 6;
    localparam int FIFO_CTRL_EN_BIT = 0;
    localparam int FIFO_CTRL_RXRST_BIT = 1;
    localparam int FIFO_CTRL_TXRST_BIT = 2;
    localparam logic [7:0] INT_EN_ENH_MASK = 8'hf0;
    localparam logic [7:0] INT_SRC_ENH_MASK = 8'h30;
    localparam logic [7:0] FIFO_CTRL_ENH_MASK = 8'h30;
    localparam logic [7:0] MODEM_CTRL_ENH_MASK = 8'he0;
    localparam logic [7:0] DIV_FRAC_MASK = 8'h0f;
    localparam logic [7:0] MODEM_STAT_RSVD_MASK = 8'h0e;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DIV_ZERO = 8'h00;
    typedef enum logic [1:0] {
        URM_BANK_STD = 2'b00,
        URM_BANK_DIV = 2'b01,
        URM_BANK_ENH = 2'b10
    } urm_bank_e;
endpackage : urm_pkg

// ---- pkg/urm_mem_if.sv ----
`timescale 1ns/1ps
interface urm_mem_if;
    logic we;
    logic [1:0] waddr;
    logic [7:0] wdata;
    logic [1:0] raddr;
    logic [7:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : urm_mem_if

// ---- verilog/urm_char_mem.sv ----
`timescale 1ns/1ps
module urm_char_mem
    import urm_pkg::*;
#(
    parameter int DEPTH = 4
)
(
    input wire logic clock,
    input wire logic reset,
    urm_mem_if.mem port
);
    logic [7:0] store [DEPTH];
    logic [7:0] rdata_q;

    // Registered read keeps the host read path one cycle behind the address
    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                store[i] <= REG_RESET;
            end
            rdata_q <= REG_RESET;
        end
        else
        begin
            if (port.we)
            begin
                store[port.waddr] <= port.wdata;
            end
            rdata_q <= store[port.raddr];
        end
    end

    assign port.rdata = rdata_q;
endmodule : urm_char_mem

// ---- verilog/urm_regs.sv ----
`timescale 1ns/1ps
module urm_regs
    import urm_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE = 8'h01, // Arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h5c // Arbitrary value
)
(
    input wire logic clock,
    input wire logic reset,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe_n,
    input wire logic [7:0] rx_data,
    input wire logic [5:0] int_source_code,
    input wire logic [7:0] line_status,
    input wire logic [7:0] modem_status,
    input wire logic [7:0] fifo_count,
    input wire logic [7:0] fifo_level,
    output logic rx_pop,
    output logic tx_load,
    output logic [7:0] tx_data,
    output logic rx_fifo_reset,
    output logic tx_fifo_reset,
    output logic [7:0] line_control,
    output logic [7:0] divisor_low,
    output logic [7:0] divisor_high,
    output logic [7:0] divisor_fraction,
    output logic [7:0] interrupt_enable,
    output logic [7:0] fifo_control,
    output logic [7:0] modem_control,
    output logic [7:0] scratch,
    output logic [7:0] enhanced_mode_select,
    output logic [7:0] fifo_trigger,
    output logic [7:0] feature_control,
    output logic [7:0] enhanced_function
);
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic rd_s1;
        logic rd_s2;
        logic wr_s1;
        logic wr_s2;
        logic [2:0] addr_s1;
        logic [2:0] addr_s2;
        logic [7:0] din_s1;
        logic [7:0] din_s2;
        logic cs_d;
        logic wr_d;
        logic rd_d;
        logic [2:0] addr_d;
        logic [7:0] din_d;
        logic [7:0] dout;
        logic doe_n;
        logic rx_pop;
        logic tx_load;
        logic [7:0] tx_data;
        logic rxf_rst;
        logic txf_rst;
        logic [7:0] line_ctrl;
        logic [7:0] div_lo;
        logic [7:0] div_hi;
        logic [7:0] div_frac;
        logic [7:0] int_en;
        logic [7:0] fifo_ctrl;
        logic [7:0] modem_ctrl;
        logic [7:0] scratch_pad;
        logic [7:0] mode_sel;
        logic [7:0] trigger;
        logic [7:0] feature;
        logic [7:0] enh_func;
    } urm_state_s;

    urm_state_s st;
    urm_state_s next_st;
    urm_mem_if chars ();
    logic rd_act;
    logic rd_start;
    logic wr_evt;
    urm_bank_e rd_bank;
    urm_bank_e wr_bank;
    logic [7:0] rd_mux;

    // Bank choice shared by the read and write decoders
    function automatic urm_bank_e bank_of(input logic [7:0] lc);
        if (lc == LINE_CTRL_ENH_KEY)
        begin
            return URM_BANK_ENH;
        end
        else if (lc[LINE_CTRL_DIV_BIT])
        begin
            return URM_BANK_DIV;
        end
        else
        begin
            return URM_BANK_STD;
        end
    endfunction : bank_of

    urm_char_mem #(
        .DEPTH(4)
    ) u_chars (
        .clock(clock),
        .reset(reset),
        .port(chars.mem)
    );

    // Write takes effect on the trailing edge of the strobe, data settled
    assign rd_act = st.cs_s2 && st.rd_s2;
    assign rd_start = rd_act && !st.rd_d;
    assign wr_evt = st.cs_d && st.wr_d && !st.wr_s2;
    assign rd_bank = bank_of(st.line_ctrl);
    assign wr_bank = bank_of(st.line_ctrl);

    assign chars.raddr = st.addr_s2[1:0];
    assign chars.we = wr_evt && (wr_bank == URM_BANK_ENH) && st.addr_d[2];
    assign chars.waddr = st.addr_d[1:0];
    assign chars.wdata = st.din_d;

    always_comb
    begin
        rd_mux = REG_RESET;
        case (st.addr_s2)
            OFF_0:
            begin
                if (rd_bank == URM_BANK_ENH)
                begin
                    rd_mux = fifo_count;
                end
                else if (rd_bank == URM_BANK_DIV)
                begin
                    if (st.div_lo == DIV_ZERO && st.div_hi == DIV_ZERO)
                    begin
                        rd_mux = REVISION_CODE;
                    end
                    else
                    begin
                        rd_mux = st.div_lo;
                    end
                end
                else
                begin
                    rd_mux = rx_data;
                end
            end
            OFF_1:
            begin
                if (rd_bank == URM_BANK_ENH)
                begin
                    rd_mux = st.feature;
                end
                else if (rd_bank == URM_BANK_DIV)
                begin
                    if (st.div_lo == DIV_ZERO && st.div_hi == DIV_ZERO)
                    begin
                        rd_mux = DEVICE_ID;
                    end
                    else
                    begin
                        rd_mux = st.div_hi;
                    end
                end
                else
                begin
                    rd_mux = st.int_en;
                end
            end
            OFF_2:
            begin
                if (rd_bank == URM_BANK_ENH)
                begin
                    rd_mux = st.enh_func;
                end
                else if (rd_bank == URM_BANK_DIV && st.enh_func[ENH_UNLOCK_BIT])
                begin
                    rd_mux = st.div_frac;
                end
                else
                begin
                    rd_mux = {{2{st.fifo_ctrl[FIFO_CTRL_EN_BIT]}}, 2'b00, int_source_code[3:0]};
                    if (st.enh_func[ENH_UNLOCK_BIT])
                    begin
                        rd_mux = rd_mux | ({2'b00, int_source_code} & INT_SRC_ENH_MASK);
                    end
                end
            end
            OFF_3:
            begin
                rd_mux = st.line_ctrl;
            end
            OFF_4:
            begin
                rd_mux = (rd_bank == URM_BANK_ENH) ? chars.rdata : st.modem_ctrl;
            end
            OFF_5:
            begin
                rd_mux = (rd_bank == URM_BANK_ENH) ? chars.rdata : line_status;
            end
            OFF_6:
            begin
                if (rd_bank == URM_BANK_ENH)
                begin
                    rd_mux = chars.rdata;
                end
                else
                begin
                    rd_mux = modem_status & ~MODEM_STAT_RSVD_MASK;
                end
            end
            OFF_7:
            begin
                if (rd_bank == URM_BANK_ENH)
                begin
                    rd_mux = chars.rdata;
                end
                else if (st.feature[FEATURE_MAP_BIT])
                begin
                    rd_mux = fifo_level;
                end
                else
                begin
                    rd_mux = st.scratch_pad;
                end
            end
            default:
            begin
                rd_mux = REG_RESET;
            end
        endcase
    end

    always_comb
    begin
        next_st = st;
        // Pins are asynchronous to the UART clock
        next_st.cs_s1 = !chip_select_n;
        next_st.cs_s2 = st.cs_s1;
        next_st.rd_s1 = !read_n;
        next_st.rd_s2 = st.rd_s1;
        next_st.wr_s1 = !write_n;
        next_st.wr_s2 = st.wr_s1;
        next_st.addr_s1 = addr;
        next_st.addr_s2 = st.addr_s1;
        next_st.din_s1 = data_in;
        next_st.din_s2 = st.din_s1;
        next_st.cs_d = st.cs_s2;
        next_st.wr_d = st.wr_s2;
        next_st.rd_d = rd_act;
        next_st.addr_d = st.addr_s2;
        next_st.din_d = st.din_s2;
        next_st.rx_pop = 1'b0;
        next_st.tx_load = 1'b0;
        next_st.rxf_rst = 1'b0;
        next_st.txf_rst = 1'b0;
        next_st.doe_n = !rd_act;
        next_st.dout = rd_act ? rd_mux : st.dout;
        // Only the receive pop is a read side effect; other reads are silent
        if (rd_start && rd_bank == URM_BANK_STD && st.addr_s2 == OFF_0)
        begin
            next_st.rx_pop = 1'b1;
        end
        // Read-only locations have no write arm, so such writes are dropped
        if (wr_evt)
        begin
            case (st.addr_d)
                OFF_0:
                begin
                    if (wr_bank == URM_BANK_ENH)
                    begin
                        next_st.trigger = st.din_d;
                    end
                    else if (wr_bank == URM_BANK_DIV)
                    begin
                        next_st.div_lo = st.din_d;
                    end
                    else
                    begin
                        next_st.tx_load = 1'b1;
                        next_st.tx_data = st.din_d;
                    end
                end
                OFF_1:
                begin
                    if (wr_bank == URM_BANK_ENH)
                    begin
                        next_st.feature = st.din_d;
                    end
                    else if (wr_bank == URM_BANK_DIV)
                    begin
                        next_st.div_hi = st.din_d;
                    end
                    else
                    begin
                        next_st.int_en = st.din_d;
                    end
                end
                OFF_2:
                begin
                    if (wr_bank == URM_BANK_ENH)
                    begin
                        next_st.enh_func = st.din_d;
                    end
                    else if (wr_bank == URM_BANK_DIV && st.enh_func[ENH_UNLOCK_BIT])
                    begin
                        next_st.div_frac = st.din_d & DIV_FRAC_MASK;
                    end
                    else
                    begin
                        next_st.fifo_ctrl = st.din_d;
                        next_st.rxf_rst = st.din_d[FIFO_CTRL_RXRST_BIT];
                        next_st.txf_rst = st.din_d[FIFO_CTRL_TXRST_BIT];
                    end
                end
                OFF_3:
                begin
                    next_st.line_ctrl = st.din_d;
                end
                OFF_4:
                begin
                    if (wr_bank != URM_BANK_ENH)
                    begin
                        next_st.modem_ctrl = st.din_d;
                    end
                end
                OFF_7:
                begin
                    if (wr_bank != URM_BANK_ENH)
                    begin
                        if (st.feature[FEATURE_MAP_BIT])
                        begin
                            next_st.mode_sel = st.din_d;
                        end
                        else
                        begin
                            next_st.scratch_pad = st.din_d;
                        end
                    end
                end
                default:
                begin
                    next_st.scratch_pad = next_st.scratch_pad;
                end
            endcase
        end
        // Clearing the enhance bit also clears what it unlocked
        if (!next_st.enh_func[ENH_UNLOCK_BIT])
        begin
            next_st.int_en = next_st.int_en & ~INT_EN_ENH_MASK;
            next_st.fifo_ctrl = next_st.fifo_ctrl & ~FIFO_CTRL_ENH_MASK;
            next_st.modem_ctrl = next_st.modem_ctrl & ~MODEM_CTRL_ENH_MASK;
            next_st.div_frac = REG_RESET;
        end
    end

    always_ff @(posedge clock or posedge reset)
    begin
        if (reset)
        begin
            st <= '0;
            st.doe_n <= 1'b1;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign data_out = st.dout;
    assign data_oe_n = st.doe_n;
    assign rx_pop = st.rx_pop;
    assign tx_load = st.tx_load;
    assign tx_data = st.tx_data;
    assign rx_fifo_reset = st.rxf_rst;
    assign tx_fifo_reset = st.txf_rst;
    assign line_control = st.line_ctrl;
    assign divisor_low = st.div_lo;
    assign divisor_high = st.div_hi;
    assign divisor_fraction = st.div_frac;
    assign interrupt_enable = st.int_en;
    assign fifo_control = st.fifo_ctrl;
    assign modem_control = st.modem_ctrl;
    assign scratch = st.scratch_pad;
    assign enhanced_mode_select = st.mode_sel;
    assign fifo_trigger = st.trigger;
    assign feature_control = st.feature;
    assign enhanced_function = st.enh_func;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_std_wr(logic [2:0] off);
        wr_evt && wr_bank == URM_BANK_STD && st.addr_d == off;
    endsequence

    sequence s_pulse(logic sig);
        sig ##1 !sig;
    endsequence

    a_line_write: assert property (wr_evt && st.addr_d == OFF_3 |=>
        line_control == $past(st.din_d))
        else $error("line control not loaded");
    a_tx_load: assert property (s_std_wr(OFF_0) |=>
        tx_load && tx_data == $past(st.din_d))
        else $error("transmit holding not loaded");
    a_rx_pop: assert property (rd_start && rd_bank == URM_BANK_STD
        && st.addr_s2 == OFF_0 |=> s_pulse(rx_pop))
        else $error("receive pop missing or long");
    a_div_write: assert property (wr_evt && wr_bank == URM_BANK_DIV
        && st.addr_d == OFF_0 |=> divisor_low == $past(st.din_d))
        else $error("divisor low not loaded");
    a_frac_lock: assert property (wr_evt && st.addr_d == OFF_2
        && !st.enh_func[ENH_UNLOCK_BIT] |=> divisor_fraction == REG_RESET)
        else $error("fraction divisor written while locked");
    a_id_read: assert property (rd_act && rd_bank == URM_BANK_DIV
        && st.div_lo == DIV_ZERO && st.div_hi == DIV_ZERO && st.addr_s2 == OFF_1
        |=> data_out == DEVICE_ID)
        else $error("device id not returned");
    a_int_en_lock: assert property (!enhanced_function[ENH_UNLOCK_BIT] |->
        (interrupt_enable & INT_EN_ENH_MASK) == REG_RESET)
        else $error("enhanced enable bits set while locked");
    a_fifo_reset: assert property (s_std_wr(OFF_2) ##0 st.din_d[FIFO_CTRL_RXRST_BIT]
        |=> s_pulse(rx_fifo_reset))
        else $error("receive FIFO reset pulse wrong");
    a_count_read: assert property (rd_act && st.line_ctrl == LINE_CTRL_ENH_KEY
        && st.addr_s2 == OFF_0 |=> data_out == $past(fifo_count))
        else $error("FIFO count not returned");
    a_bus_release: assert property (!rd_act |=> data_oe_n)
        else $error("data bus driven without a read");
endmodule : urm_regs

// ---- testbench/urm_host_model.sv ----
`timescale 1ns/1ps
module urm_host_model
    import urm_pkg::*;
(
    input wire logic clock,
    input wire logic [7:0] data_out,
    input wire logic data_oe_n,
    output logic chip_select_n,
    output logic read_n,
    output logic write_n,
    output logic [2:0] addr,
    output logic [7:0] data_in,
    output logic hang,
    output logic drove
);
    initial
    begin
        chip_select_n = 1'b1;
        read_n = 1'b1;
        write_n = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
        hang = 1'b0;
        drove = 1'b0;
    end

    task automatic pause(input int n);
        repeat (n) @(negedge clock);
    endtask : pause

    // Write strobes held 4 clocks (read strobes until the bus drives, then 4), pins held 4 more, 6 idle: above the 3-clock syncer minimum
    task automatic access(input bit wr, input bit sel, input logic [2:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge clock);
        drove = 1'b0;
        chip_select_n = !sel;
        addr = a;
        data_in = d;
        if (wr)
            write_n = 1'b0;
        else
            read_n = 1'b0;
        n = 0;
        while (!wr && sel && data_oe_n !== 1'b0 && n < 12)
        begin
            pause(1);
            n++;
        end
        if (n == 12)
            hang = 1'b1;
        pause(4);
        if (data_oe_n === 1'b0)
            drove = 1'b1;
        q = data_out;
        write_n = 1'b1;
        read_n = 1'b1;
        pause(4);
        chip_select_n = 1'b1;
        // Released lines flip so a stale byte cannot pass for fresh data
        data_in = ~d;
        addr = ~a;
        pause(6);
    endtask : access
endmodule : urm_host_model

// ---- testbench/tb_uart_register_map_decoder.sv ----
`timescale 1ns/1ps
module tb_uart_register_map_decoder;
    import urm_pkg::*;
    localparam logic [7:0] REV = 8'h2e; // Arbitrary value
    localparam logic [7:0] DEVID = 8'h71; // Arbitrary value
    logic clock, reset, chip_select_n, read_n, write_n, hang, drove, data_oe_n;
    logic rx_pop, tx_load, rx_fifo_reset, tx_fifo_reset;
    logic [2:0] addr;
    logic [5:0] int_source_code;
    logic [7:0] data_in, data_out, rx_data, line_status, modem_status, fifo_count, fifo_level;
    logic [7:0] tx_data, line_control, divisor_low, divisor_high, divisor_fraction;
    logic [7:0] interrupt_enable, fifo_control, modem_control, scratch, enhanced_mode_select;
    logic [7:0] fifo_trigger, feature_control, enhanced_function;
    int mismatches, n_checks, n_pop, n_load, n_rrst, n_trst;

    urm_regs #(.REVISION_CODE(REV), .DEVICE_ID(DEVID)) u_urm_regs (
        .clock, .reset, .chip_select_n, .read_n, .write_n, .addr, .data_in, .data_out,
        .data_oe_n, .rx_data, .int_source_code, .line_status, .modem_status, .fifo_count,
        .fifo_level, .rx_pop, .tx_load, .tx_data, .rx_fifo_reset, .tx_fifo_reset,
        .line_control, .divisor_low, .divisor_high, .divisor_fraction, .interrupt_enable,
        .fifo_control, .modem_control, .scratch, .enhanced_mode_select, .fifo_trigger,
        .feature_control, .enhanced_function);

    urm_host_model u_urm_host_model (
        .clock, .data_out, .data_oe_n, .chip_select_n, .read_n, .write_n, .addr,
        .data_in, .hang, .drove);

    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (rx_pop === 1'b1) n_pop++;
        if (tx_load === 1'b1) n_load++;
        if (rx_fifo_reset === 1'b1) n_rrst++;
        if (tx_fifo_reset === 1'b1) n_trst++;
    end

    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("Error %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_urm_host_model.access(1'b1, 1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        u_urm_host_model.access(1'b0, 1'b1, a, 8'h00, q);
        if (hang === 1'b1)
        begin
            $display("Error %s expected %h seen %h", "read answer", 8'h00, 8'hff);
            mismatches++;
            tally_and_finish();
        end
        else
            chk(what, exp, q);
    endtask : rd

    task automatic t_standard();
        wr(OFF_3, 8'h03);
        rd(OFF_3, 8'h03, "line control");
        wr(OFF_1, 8'hff);
        rd(OFF_1, 8'h0f, "int enable locked");
        wr(OFF_4, 8'he3);
        chk("modem control locked", 8'h03, modem_control);
        wr(OFF_7, 8'h5a);
        rd(OFF_7, 8'h5a, "scratch");
        rd(OFF_0, rx_data, "rx holding");
        chk("pop count", 8'h01, 8'(n_pop));
        wr(OFF_0, 8'hc6);
        chk("tx data", 8'hc6, tx_data);
        chk("load count", 8'h01, 8'(n_load));
        wr(OFF_2, 8'hf9);
        chk("fifo control locked", 8'hc9, fifo_control);
        wr(OFF_2, 8'h07);
        chk("rx fifo reset", 8'h01, 8'(n_rrst));
        chk("tx fifo reset", 8'h01, 8'(n_trst));
        rd(OFF_2, {2'b11, 2'b00, int_source_code[3:0]}, "int source locked");
        rd(OFF_5, line_status, "line status");
        rd(OFF_6, modem_status & ~MODEM_STAT_RSVD_MASK, "modem status");
        wr(OFF_5, 8'h00);
        wr(OFF_6, 8'h00);
        chk("line control kept", 8'h03, line_control);
        rd(OFF_7, 8'h5a, "scratch kept");
    endtask : t_standard

    task automatic t_divisor();
        wr(OFF_3, 8'h80);
        rd(OFF_0, REV, "revision");
        rd(OFF_1, DEVID, "device id");
        wr(OFF_0, 8'h12);
        wr(OFF_1, 8'h34);
        rd(OFF_0, 8'h12, "div low");
        rd(OFF_1, 8'h34, "div high");
        chk("no pop", 8'h01, 8'(n_pop));
    endtask : t_divisor

    task automatic t_enhanced();
        wr(OFF_3, LINE_CTRL_ENH_KEY);
        rd(OFF_3, LINE_CTRL_ENH_KEY, "line control key");
        wr(OFF_2, 8'h10);
        rd(OFF_2, 8'h10, "enhanced function");
        wr(OFF_1, 8'h40);
        rd(OFF_1, 8'h40, "feature control");
        wr(OFF_0, 8'h77);
        chk("trigger", 8'h77, fifo_trigger);
        chk("no load", 8'h01, 8'(n_load));
        rd(OFF_0, fifo_count, "fifo count");
        for (int i = 4; i < 8; i++)
            wr(3'(i), 8'(8'h30 + i));
        for (int i = 4; i < 8; i++)
            rd(3'(i), 8'(8'h30 + i), "flow char");
        chk("modem control untouched", 8'h03, modem_control);
    endtask : t_enhanced

    task automatic t_unlocked();
        logic [7:0] q;
        wr(OFF_3, 8'h80);
        wr(OFF_2, 8'hf5);
        rd(OFF_2, 8'h05, "fraction");
        wr(OFF_3, 8'h03);
        wr(OFF_1, 8'hff);
        rd(OFF_1, 8'hff, "int enable open");
        wr(OFF_4, 8'he3);
        rd(OFF_4, 8'he3, "modem control open");
        rd(OFF_2, {2'b11, int_source_code}, "int source open");
        rd(OFF_7, fifo_level, "fifo level");
        wr(OFF_7, 8'hc3);
        chk("mode select", 8'hc3, enhanced_mode_select);
        chk("scratch kept", 8'h5a, scratch);
        u_urm_host_model.access(1'b0, 1'b0, OFF_3, 8'h00, q);
        chk("unselected drive", 8'h00, {7'h00, drove});
    endtask : t_unlocked

    initial
    begin
        reset = 1'b1;
        rx_data = 8'ha5;
        int_source_code = 6'h3c;
        line_status = 8'h61;
        modem_status = 8'hff;
        fifo_count = 8'h2b;
        fifo_level = 8'h4d;
        repeat (20) @(negedge clock);
        reset = 1'b0;
        t_standard();
        t_divisor();
        t_enhanced();
        t_unlocked();
        tally_and_finish();
    end
endmodule : tb_uart_register_map_decoder
